// file: src/block_cfg_pkg.sv
// constants, types and helpers shared by the block function configuration logic
package block_cfg_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_FUNC_CFG = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] OFS_BLOCK_STATE = 8'h10;
    localparam int ADDR_DEC_W = 8;
    localparam logic [1:0] ADDR_ALIGN_MASK = 2'h3;

    // function configuration register layout
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    localparam int FN_LSB = 0;
    localparam int FN_W = 3;
    localparam int MODE0_BIT = 3;
    localparam int MODE1_BIT = 4;
    localparam int CHAIN_LAST_BIT = 5;

    // function select codes
    typedef enum logic [2:0] {
        FN_TIMER = 3'h0,
        FN_COUNTER = 3'h1,
        FN_CRC_PRS = 3'h2,
        FN_DEADBAND = 3'h4,
        FN_UART = 3'h5,
        FN_SPI = 3'h6
    } fn_t;

    // interrupt status, enable and clear layout
    localparam int IRQ_W = 2;
    localparam int IRQ_BLOCK_BIT = 0;
    localparam int IRQ_CMP_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // block state register layout
    localparam int STATE_SRC_BIT = 0;
    localparam int STATE_CMP_BIT = 1;

    // bus encodings
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ_WAIT,
        PH_READ_DATA
    } phase_t;

    function automatic logic [FN_W-1:0] cfg_function(input logic [CFG_W-1:0] cfg);
        return cfg[FN_LSB +: FN_W];
    endfunction : cfg_function

    function automatic logic is_count_fn(input logic [FN_W-1:0] code);
        return (code == FN_TIMER) || (code == FN_COUNTER);
    endfunction : is_count_fn

endpackage : block_cfg_pkg

// file: src/compare_unit.sv
// count versus compare value test with selectable strictness
`timescale 1ns/1ns
module compare_unit #(
    parameter int CNT_W = 8
) (
    input wire logic [CNT_W-1:0] count_value,
    input wire logic [CNT_W-1:0] compare_value,
    input wire logic less_than,
    input wire logic active,
    output logic compare_true
);

    // strict test only when asked; outside timer and counter the result is held low
    always_comb begin
        if (!active) begin
            compare_true = 1'b0;
        end else if (less_than) begin
            compare_true = count_value < compare_value; // R5
        end else begin
            compare_true = count_value <= compare_value; // R5
        end
    end

endmodule : compare_unit

// file: src/irq_status_bank.sv
// sticky event status with enable mask and write-one-to-clear
`timescale 1ns/1ns
module irq_status_bank #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] set_ev,
    input wire logic wr_enable,
    input wire logic wr_clear,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status,
    output logic [W-1:0] enable,
    output logic irq
);

    logic [W-1:0] status_q;
    logic [W-1:0] status_d;
    logic [W-1:0] enable_q;
    logic [W-1:0] enable_d;
    logic irq_q;

    // an event in the clearing cycle survives the clear
    always_comb begin
        status_d = (status_q & ~(wr_clear ? wdata : {W{1'b0}})) | set_ev;
        enable_d = wr_enable ? wdata : enable_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= {W{1'b0}};
            enable_q <= {W{1'b0}};
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= status_d;
            enable_q <= enable_d;
            irq_q <= |(status_d & enable_d);
        end
    end

    assign status = status_q;
    assign enable = enable_q;
    assign irq = irq_q;

endmodule : irq_status_bank

// file: src/digital_block_function_select.sv
// function configuration register of a digital block with AHB-Lite access and interrupt
//
// Operation
// R1: bits 7 and 6 are stored and read back but steer nothing.
// R2: chain-last at 1 marks the last or a lone block, at 0 a following block continues.
// R3: software never clears chain-last in the final communications block.
// R4: the meaning of mode bit 4 depends only on the current function select code.
// R5: in timer and counter, bit 4 at 0 compares less-or-equal, at 1 strictly less.
// R6: in UART, bit 4 at 0 interrupts on transmit holding empty, at 1 on transmit done.
// R7: in SPI with bit 4 at 1, master and slave both interrupt on transfer complete.
// R8: in SPI with bit 4 at 0, a master interrupts on transmit empty, a slave on receive full.
// R9: in timer and counter, bit 3 at 0 interrupts on terminal count, at 1 on compare true.
// R10: in UART, bit 3 at 0 makes a receiver and at 1 a transmitter.
// R11: in SPI, bit 3 at 0 makes a master and at 1 a slave.
// R12: bits 2 to 0 select the block function.
// R13: function code 000 is a chainable timer.
// R14: reset clears the whole register to zero and all bits are read and write.
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module digital_block_function_select #(
    parameter int CNT_W = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire logic [CNT_W-1:0] COUNT_VALUE,
    input wire logic [CNT_W-1:0] COMPARE_VALUE,
    input wire logic TERMINAL_COUNT,
    input wire logic TX_REG_EMPTY,
    input wire logic TX_COMPLETE,
    input wire logic RX_REG_FULL,
    input wire logic SPI_COMPLETE,
    output logic [2:0] FUNCTION_SEL,
    output logic CHAIN_LAST,
    output logic COMPARE_LT,
    output logic IRQ_ON_COMPARE,
    output logic UART_TRANSMIT,
    output logic UART_IRQ_ON_DONE,
    output logic SPI_SLAVE,
    output logic SPI_IRQ_ON_DONE,
    output logic COMPARE_TRUE,
    output logic BLOCK_EVENT,
    output logic IRQ
);

    // bus slave state
    block_cfg_pkg::phase_t phase_q;
    logic [block_cfg_pkg::ADDR_DEC_W-1:0] addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_word;
    logic take;
    logic wr_now;
    logic wr_cfg;
    logic wr_irq_enable;
    logic wr_irq_clear;

    // configuration and decode
    logic [block_cfg_pkg::CFG_W-1:0] cfg_q;
    logic [block_cfg_pkg::FN_W-1:0] fn_code;
    logic mode0;
    logic mode1;
    logic count_fn;
    logic cmp_now;
    logic sel_src;
    logic src_q;
    logic cmp_q;
    logic [block_cfg_pkg::IRQ_W-1:0] events;
    logic [block_cfg_pkg::IRQ_W-1:0] irq_status;
    logic [block_cfg_pkg::IRQ_W-1:0] irq_enable;

    // decoded control flops, one per output
    logic [2:0] fn_sel_q;
    logic chain_last_q;
    logic compare_lt_q;
    logic irq_on_compare_q;
    logic uart_transmit_q;
    logic uart_irq_on_done_q;
    logic spi_slave_q;
    logic spi_irq_on_done_q;

    // ---------------- bus slave ----------------

    // size is ignored: every access moves a whole word
    // address bits above the decoded byte alias onto the same registers
    assign take = HSEL && HREADY && HTRANS[block_cfg_pkg::HTRANS_ACTIVE_BIT];

    // a read spends one wait cycle so a write just before it is always visible;
    // a low clock enable stalls the bus instead of dropping a transfer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            phase_q <= block_cfg_pkg::PH_IDLE;
        end else if (CE) begin
            case (phase_q)
                block_cfg_pkg::PH_READ_WAIT: begin
                    phase_q <= block_cfg_pkg::PH_READ_DATA;
                end
                default: begin
                    if (take && HWRITE) begin
                        phase_q <= block_cfg_pkg::PH_WRITE;
                    end else if (take) begin
                        phase_q <= block_cfg_pkg::PH_READ_WAIT;
                    end else begin
                        phase_q <= block_cfg_pkg::PH_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            addr_q <= '0;
        end else if (CE && take) begin
            addr_q <= HADDR[block_cfg_pkg::ADDR_DEC_W-1:0]
                      & ~{{(block_cfg_pkg::ADDR_DEC_W-2){1'b0}}, block_cfg_pkg::ADDR_ALIGN_MASK};
        end
    end

    assign HREADYOUT = CE && (phase_q != block_cfg_pkg::PH_READ_WAIT);
    // never an error: unmapped offsets read zero and drop writes
    assign HRESP = block_cfg_pkg::HRESP_OKAY;
    assign wr_now = CE && (phase_q == block_cfg_pkg::PH_WRITE);
    // one write strobe per register keeps the address decode in one place
    assign wr_cfg = wr_now && (addr_q == block_cfg_pkg::OFS_FUNC_CFG);
    assign wr_irq_enable = wr_now && (addr_q == block_cfg_pkg::OFS_IRQ_ENABLE);
    assign wr_irq_clear = wr_now && (addr_q == block_cfg_pkg::OFS_IRQ_CLEAR);

    // unmapped offsets and the clear register read as zero
    // the clear register reads zero so a read-modify-write never clears by accident
    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            block_cfg_pkg::OFS_FUNC_CFG: begin
                rd_word = 32'(cfg_q); // R14
            end
            block_cfg_pkg::OFS_IRQ_STATUS: begin
                rd_word = 32'(irq_status);
            end
            block_cfg_pkg::OFS_IRQ_ENABLE: begin
                rd_word = 32'(irq_enable);
            end
            block_cfg_pkg::OFS_BLOCK_STATE: begin
                rd_word[block_cfg_pkg::STATE_SRC_BIT] = src_q;
                rd_word[block_cfg_pkg::STATE_CMP_BIT] = cmp_q;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            hrdata_q <= block_cfg_pkg::RDATA_RESET;
        end else if (CE && phase_q == block_cfg_pkg::PH_READ_WAIT) begin
            hrdata_q <= rd_word;
        end
    end

    assign HRDATA = hrdata_q;

    // ---------------- function configuration register ----------------

    // no guard on chain-last: keeping it set in the final communications block is up to software
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cfg_q <= block_cfg_pkg::CFG_RESET; // R14
        end else if (wr_cfg) begin
            cfg_q <= HWDATA[block_cfg_pkg::CFG_W-1:0]; // R14
        end
    end

    // bits 7:6 are never looked at below
    assign fn_code = block_cfg_pkg::cfg_function(cfg_q); // R12 R1
    assign mode0 = cfg_q[block_cfg_pkg::MODE0_BIT];
    assign mode1 = cfg_q[block_cfg_pkg::MODE1_BIT];
    assign count_fn = block_cfg_pkg::is_count_fn(fn_code); // R13

    // outside timer and counter the compare is held inactive, so stale mode bits do no harm
    compare_unit #(
        .CNT_W(CNT_W)
    ) u_compare (
        .count_value(COUNT_VALUE),
        .compare_value(COMPARE_VALUE),
        .less_than(mode1),
        .active(count_fn),
        .compare_true(cmp_now)
    );

    // interrupt source follows the live function code, so a function change
    // reinterprets the mode bits at once
    always_comb begin
        sel_src = 1'b0;
        case (fn_code) // R4
            block_cfg_pkg::FN_TIMER,
            block_cfg_pkg::FN_COUNTER: begin
                sel_src = mode0 ? cmp_now : TERMINAL_COUNT; // R9
            end
            block_cfg_pkg::FN_UART: begin
                if (mode0) begin
                    sel_src = mode1 ? TX_COMPLETE : TX_REG_EMPTY; // R6 R10
                end else begin
                    sel_src = RX_REG_FULL; // R10
                end
            end
            block_cfg_pkg::FN_SPI: begin
                if (mode1) begin
                    sel_src = SPI_COMPLETE; // R7
                end else if (mode0) begin
                    sel_src = RX_REG_FULL; // R8 R11
                end else begin
                    sel_src = TX_REG_EMPTY; // R8 R11
                end
            end
            block_cfg_pkg::FN_CRC_PRS,
            block_cfg_pkg::FN_DEADBAND: begin
                sel_src = TERMINAL_COUNT;
            end
            default: begin
                sel_src = 1'b0;
            end
        endcase
    end

    // decoded controls are registered, one cycle behind the configuration,
    // which trades a cycle of latency for glitch-free control lines
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fn_sel_q <= 3'h0;
            chain_last_q <= 1'b0;
            compare_lt_q <= 1'b0;
            irq_on_compare_q <= 1'b0;
            uart_transmit_q <= 1'b0;
            uart_irq_on_done_q <= 1'b0;
            spi_slave_q <= 1'b0;
            spi_irq_on_done_q <= 1'b0;
        end else if (CE) begin
            fn_sel_q <= fn_code; // R12
            chain_last_q <= cfg_q[block_cfg_pkg::CHAIN_LAST_BIT]; // R2
            compare_lt_q <= count_fn && mode1; // R5
            irq_on_compare_q <= count_fn && mode0; // R9
            uart_transmit_q <= (fn_code == block_cfg_pkg::FN_UART) && mode0; // R10
            uart_irq_on_done_q <= (fn_code == block_cfg_pkg::FN_UART) && mode0 && mode1; // R6
            spi_slave_q <= (fn_code == block_cfg_pkg::FN_SPI) && mode0; // R11
            spi_irq_on_done_q <= (fn_code == block_cfg_pkg::FN_SPI) && mode1; // R7
        end
    end

    assign FUNCTION_SEL = fn_sel_q;
    assign CHAIN_LAST = chain_last_q;
    assign COMPARE_LT = compare_lt_q;
    assign IRQ_ON_COMPARE = irq_on_compare_q;
    assign UART_TRANSMIT = uart_transmit_q;
    assign UART_IRQ_ON_DONE = uart_irq_on_done_q;
    assign SPI_SLAVE = spi_slave_q;
    assign SPI_IRQ_ON_DONE = spi_irq_on_done_q;

    // ---------------- events and interrupt ----------------

    always_ff @(posedge CLK) begin
        if (RESET) begin
            src_q <= 1'b0;
            cmp_q <= 1'b0;
        end else if (CE) begin
            src_q <= sel_src;
            cmp_q <= cmp_now;
        end
    end

    assign BLOCK_EVENT = src_q;
    assign COMPARE_TRUE = cmp_q;

    // rising edges only, so a source held high raises the flag once
    // the compare edge uses the raw result, so it flags even when not the selected source
    always_comb begin
        events = '0;
        events[block_cfg_pkg::IRQ_BLOCK_BIT] = sel_src && !src_q;
        events[block_cfg_pkg::IRQ_CMP_BIT] = cmp_now && !cmp_q;
    end

    // status and enable share one layout, so one data slice feeds both
    irq_status_bank #(
        .W(block_cfg_pkg::IRQ_W)
    ) u_irq (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .set_ev(events),
        .wr_enable(wr_irq_enable),
        .wr_clear(wr_irq_clear),
        .wdata(HWDATA[block_cfg_pkg::IRQ_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(IRQ)
    );

endmodule : digital_block_function_select

// file: bench/block_cfg_properties.sv
// assertions on configuration decode and bus timing of the function register
`timescale 1ns/1ns
module block_cfg_checker (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [2:0] FUNCTION_SEL,
    input wire logic CHAIN_LAST,
    input wire logic COMPARE_LT,
    input wire logic IRQ_ON_COMPARE,
    input wire logic UART_TRANSMIT,
    input wire logic UART_IRQ_ON_DONE,
    input wire logic SPI_SLAVE,
    input wire logic SPI_IRQ_ON_DONE,
    input wire logic IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic wr_q;
    logic [7:0] sh_q;
    wire logic tk = HSEL && HREADY && HTRANS[1] && CE;
    wire logic cnt = sh_q[2:1] == 2'h0;
    wire logic uart = sh_q[2:0] == block_cfg_pkg::FN_UART;
    wire logic spi = sh_q[2:0] == block_cfg_pkg::FN_SPI;
    // shadow copy of the register, loaded where the write data phase completes
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wr_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (CE && HREADY) begin
            wr_q <= tk && HWRITE && HADDR[7:2] == 6'h00;
            if (wr_q) sh_q <= HWDATA[7:0];
        end
    end
    chk_fn_select: assert property (CE |=> FUNCTION_SEL == $past(sh_q[2:0]))
        else $error("function select differs from register");
    chk_chain_flag: assert property (CE |=> CHAIN_LAST == $past(sh_q[5]))
        else $error("chain flag differs from register");
    chk_compare_type: assert property (CE ##1 1'b1 |-> COMPARE_LT == $past(cnt && sh_q[4]))
        else $error("compare type decode wrong");
    chk_count_irq_src: assert property (CE |=> IRQ_ON_COMPARE == $past(cnt && sh_q[3]))
        else $error("count interrupt source decode wrong");
    chk_uart_dir: assert property (CE |=> UART_TRANSMIT == $past(uart && sh_q[3]))
        else $error("uart direction decode wrong");
    chk_uart_irq_type: assert property (CE |=> UART_IRQ_ON_DONE == $past(uart && sh_q[3] && sh_q[4]))
        else $error("uart interrupt type decode wrong");
    chk_spi_role: assert property (CE |=> SPI_SLAVE == $past(spi && sh_q[3]))
        else $error("spi role decode wrong");
    chk_spi_irq_type: assert property (CE |=> SPI_IRQ_ON_DONE == $past(spi && sh_q[4]))
        else $error("spi interrupt type decode wrong");
    chk_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 (HREADYOUT || !CE))
        else $error("read wait state wrong");
    chk_resp_okay: assert property (HRESP == block_cfg_pkg::HRESP_OKAY)
        else $error("response not okay");
    cov_irq: cover property ($rose(IRQ));
    cov_spi_done: cover property (SPI_IRQ_ON_DONE && SPI_SLAVE);
    cov_uart_tx: cover property (UART_IRQ_ON_DONE);
endmodule : block_cfg_checker

// file: bench/digital_block_function_select_test.sv
// self-checking test of the block function configuration register
`timescale 1ns/1ns
module digital_block_function_select_test;
    logic CLK, RESET, CE, HSEL, HWRITE, HREADYOUT, HRESP, CHAIN_LAST, COMPARE_LT;
    logic IRQ_ON_COMPARE, UART_TRANSMIT, UART_IRQ_ON_DONE, SPI_SLAVE, SPI_IRQ_ON_DONE;
    logic COMPARE_TRUE, BLOCK_EVENT, IRQ;
    logic [31:0] HADDR, HWDATA, HRDATA, rd, r;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE, FUNCTION_SEL;
    logic [7:0] cv, mv, c;
    logic [4:0] ev;
    logic [2:0] fns [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    wire logic HREADY = HREADYOUT;
    int mismatches, tests_run, cycles, seed, i;

    digital_block_function_select #(.CNT_W(8)) digital_block_function_select_inst (
        .CLK(CLK), .RESET(RESET), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .COUNT_VALUE(cv),
        .COMPARE_VALUE(mv), .TERMINAL_COUNT(ev[4]), .TX_REG_EMPTY(ev[3]),
        .TX_COMPLETE(ev[2]), .RX_REG_FULL(ev[1]), .SPI_COMPLETE(ev[0]),
        .FUNCTION_SEL(FUNCTION_SEL), .CHAIN_LAST(CHAIN_LAST), .COMPARE_LT(COMPARE_LT),
        .IRQ_ON_COMPARE(IRQ_ON_COMPARE), .UART_TRANSMIT(UART_TRANSMIT),
        .UART_IRQ_ON_DONE(UART_IRQ_ON_DONE), .SPI_SLAVE(SPI_SLAVE),
        .SPI_IRQ_ON_DONE(SPI_IRQ_ON_DONE), .COMPARE_TRUE(COMPARE_TRUE),
        .BLOCK_EVENT(BLOCK_EVENT), .IRQ(IRQ));

    function automatic logic [9:0] exp_dec(input logic [7:0] c);
        logic n, u, s;
        n = c[2:1] == 2'h0;
        u = c[2:0] == block_cfg_pkg::FN_UART;
        s = c[2:0] == block_cfg_pkg::FN_SPI;
        return {c[2:0], c[5], n & c[4], n & c[3], u & c[3], u & c[3] & c[4], s & c[3], s & c[4]};
    endfunction : exp_dec

    function automatic logic exp_src(input logic [7:0] c, input logic [4:0] e, input logic m);
        case (c[2:0])
            3'h0, 3'h1: return c[3] ? m : e[4];
            3'h2, 3'h4: return e[4];
            3'h5: return c[3] ? (c[4] ? e[2] : e[3]) : e[1];
            3'h6: return c[4] ? e[0] : (c[3] ? e[1] : e[3]);
            default: return 1'b0;
        endcase
    endfunction : exp_src

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // entered just after a rising edge; returns just after the data phase edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        rd = HRDATA;
    endtask : xfer

    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        {RESET, CE, HSEL, HWRITE, HTRANS, HADDR, HWDATA, cv, mv, ev} = '0;
        RESET = 1'b1;
        CE = 1'b1;
        HSIZE = 3'h2;
        seed = 31;
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        #1 check({BLOCK_EVENT, COMPARE_TRUE, IRQ}, 3'h2);
        check({FUNCTION_SEL, CHAIN_LAST, COMPARE_LT, SPI_SLAVE, IRQ}, 0);
        xfer(1'b0, 8'h00, 0);
        check(rd, 0);
        // first half walks every code and mode pair, second half is fully random
        for (i = 0; i < 48; i++) begin
            r = $random(seed);
            c = i < 24 ? {r[26:24], i[1:0], fns[i / 4]} : r[7:0];
            xfer(1'b1, 8'h00, {r[31:8], c});
            xfer(1'b0, 8'h00, 0);
            check(rd, {24'h0, c});
            check({FUNCTION_SEL, CHAIN_LAST, COMPARE_LT, IRQ_ON_COMPARE, UART_TRANSMIT,
                   UART_IRQ_ON_DONE, SPI_SLAVE, SPI_IRQ_ON_DONE}, exp_dec(c));
            cv <= r[7:0];
            mv <= i[0] ? r[7:0] : r[15:8];
            ev <= r[20:16];
            @(posedge CLK);
            #1 check(COMPARE_TRUE, c[2:1] == 0 && (c[4] ? cv < mv : cv <= mv));
            check(BLOCK_EVENT, exp_src(c, ev, c[4] ? cv < mv : cv <= mv));
        end
        ev <= 5'h00;
        xfer(1'b1, 8'h00, 32'h20);
        xfer(1'b1, 8'h0c, 32'h3);
        xfer(1'b1, 8'h08, 32'h1);
        ev <= 5'h10;
        @(posedge CLK);
        #1 check(IRQ, 1);
        xfer(1'b0, 8'h04, 0);
        check(rd[0], 1);
        xfer(1'b1, 8'h0c, 32'h1);
        #1 check(IRQ, 0);
        xfer(1'b1, 8'h08, 32'h0);
        ev <= 5'h00;
        @(posedge CLK);
        ev <= 5'h10;
        @(posedge CLK);
        #1 check(IRQ, 0);
        xfer(1'b0, 8'h04, 0);
        check(rd[0], 1);
        xfer(1'b0, 8'h0c, 0);
        check(rd, 0);
        xfer(1'b0, 8'h20, 0);
        check(rd, 0);
        check(HRESP, 0);
        cv <= 8'h05;
        mv <= 8'h04;
        xfer(1'b1, 8'h0c, 32'h2);
        xfer(1'b1, 8'h08, 32'h2);
        #1 check(IRQ, 0);
        mv <= 8'h05;
        @(posedge CLK);
        #1 check(IRQ, 1);
        xfer(1'b0, 8'h04, 0);
        check(rd, 32'h3);
        xfer(1'b0, 8'h08, 0);
        check(rd, 32'h2);
        xfer(1'b0, 8'h10, 0);
        check(rd, 32'h3);
        CE <= 1'b0;
        ev <= 5'h00;
        repeat (2) @(posedge CLK);
        #1 check({HREADYOUT, BLOCK_EVENT, IRQ}, 3'h3);
        CE <= 1'b1;
        @(posedge CLK);
        #1 check(BLOCK_EVENT, 0);
        print_verdict();
    end
endmodule : digital_block_function_select_test

bind digital_block_function_select block_cfg_checker block_cfg_checker_inst (
    .CLK(CLK), .RESET(RESET), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .FUNCTION_SEL(FUNCTION_SEL), .CHAIN_LAST(CHAIN_LAST),
    .COMPARE_LT(COMPARE_LT), .IRQ_ON_COMPARE(IRQ_ON_COMPARE),
    .UART_TRANSMIT(UART_TRANSMIT), .UART_IRQ_ON_DONE(UART_IRQ_ON_DONE),
    .SPI_SLAVE(SPI_SLAVE), .SPI_IRQ_ON_DONE(SPI_IRQ_ON_DONE), .IRQ(IRQ));
